//--- inc/host_power_pkg.sv
// package for the host power state and configuration commit block
// assumes a 40 MHz core clock and a byte-wide decoded register port
package host_power_pkg;

    // ==========================================================
    // register map (byte addresses on the register port)
    localparam logic [7:0]  ADDR_THR_LO      = 8'h0A;   // shutdown threshold, low byte
    localparam logic [7:0]  ADDR_THR_HI      = 8'h0B;   // shutdown threshold, high byte
    localparam logic [7:0]  ADDR_COMMIT      = 8'h19;   // configuration commit
    localparam logic [7:0]  ADDR_HOST_UP     = 8'h1C;   // host running flag

    // ==========================================================
    // values
    localparam logic [7:0]  COMMIT_KEY       = 8'h46;   // key that starts a commit
    localparam logic [7:0]  COMMIT_READ_VAL  = 8'h00;   // commit register always reads this
    localparam logic [15:0] THR_RESET        = 16'h025C; // 604 counts, 4.88 mV each
    localparam logic [7:0]  BYTE_ZERO        = 8'h00;   // unmapped reads and cleared flag
    localparam logic [7:0]  FLAG_SET         = 8'h01;   // flag value while host runs

    // ==========================================================
    // timing
    localparam int          CLK_HZ           = 40000000; // core clock rate
    localparam int          CYC_PER_MS       = CLK_HZ / 1000;
    localparam int          LAMP_HALF_MS     = 500;     // half period of the pulsing lamp
    localparam int          SHDN_DELAY_MS    = 5000;    // host shutdown grace time

    // ==========================================================
    // host power states, one-hot
    typedef enum logic [3:0] {
        ST_OFF  = 4'b0001,                               // host unpowered
        ST_BOOT = 4'b0010,                               // powered, booting
        ST_RUN  = 4'b0100,                               // daemon reported up
        ST_SHDN = 4'b1000                                // shutting down
    } host_state_t;

endpackage

//--- hw/host_power_ctrl.sv
// host running flag, indicator lamp, host power switch and config commit
// assumes a decoded register port (one access per strobe) and an external
// non-volatile store that presents its contents after reset
`timescale 1ns/1ps

// Behaviour
// - volatile one-byte host flag at 0x1C
// - flag zero while host off or booting
// - flag one: lamp steady, touch enabled
// - touch or low battery clears flag
// - shutting down: lamp pulses, then power off
// - writing zero to flag starts shutdown
// - one-byte commit register at 0x19, default zero
// - key 0x46 copies backed config to store
// - other commit values do nothing
// - commit register always reads zero
// - uncommitted changes lost, committed restored
// - shutdown threshold two bytes, default 604
module host_power_ctrl #(
    parameter int LAMP_HALF_CYC = host_power_pkg::LAMP_HALF_MS * host_power_pkg::CYC_PER_MS,
    parameter int SHDN_CYC      = host_power_pkg::SHDN_DELAY_MS * host_power_pkg::CYC_PER_MS,
    parameter int CNT_W         = 32
) (
    input  wire logic        CORE_CLK,    // core clock
    input  wire logic        RSTN,        // async reset, active low
    input  wire logic        CE,          // clock enable, freezes all state when low
    input  wire logic        REG_WR,      // register write strobe
    input  wire logic        REG_RD,      // register read strobe
    input  wire logic [7:0]  REG_ADDR,    // register address
    input  wire logic [7:0]  REG_WDATA,   // register write data
    output logic      [7:0]  REG_RDATA,   // register read data
    input  wire logic        TOUCH,       // touch pad pressed
    input  wire logic [15:0] VBAT,        // measured battery voltage in counts
    input  wire logic [15:0] NV_RDATA,    // stored threshold
    input  wire logic        NV_VALID,    // store holds a committed value
    output logic             NV_WR,       // one-cycle store write pulse
    output logic      [15:0] NV_WDATA,    // value to store
    output logic             HOST_POWER,  // host supply switch on
    output logic             LAMP         // power indicator lamp on
);
    import host_power_pkg::*;

    // ==========================================================
    // parameter checks
    generate
        if (CNT_W < 2 || CNT_W > 32 || LAMP_HALF_CYC < 1 || SHDN_CYC < 1 ||
            longint'(LAMP_HALF_CYC) >= (64'd1 << CNT_W) || longint'(SHDN_CYC) >= (64'd1 << CNT_W)) begin : g_bad
            $error("host_power_ctrl: counter too narrow or counts below one");
        end
    endgenerate

    localparam logic [CNT_W-1:0] LAMP_LAST = CNT_W'(LAMP_HALF_CYC - 1); // lamp toggles after this
    localparam logic [CNT_W-1:0] SHDN_LAST = CNT_W'(SHDN_CYC - 1);      // power drops after this
    localparam logic [CNT_W-1:0] CNT_ZERO  = '0;
    localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

    // address match, used for writes and reads
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ==========================================================
    // state
    host_state_t      state_r, state_nxt;       // host power state
    logic [7:0]       flag_r, flag_nxt;         // host running flag
    logic [15:0]      thr_r, thr_nxt;           // shutdown threshold, volatile copy
    logic             loaded_r, loaded_nxt;     // store contents taken after reset
    logic [CNT_W-1:0] lamp_cnt_r, lamp_cnt_nxt; // lamp pulse timer
    logic [CNT_W-1:0] shdn_cnt_r, shdn_cnt_nxt; // shutdown grace timer
    logic [7:0]       rdata_r, rdata_nxt;       // read data
    logic             nv_wr_r, nv_wr_nxt;       // store write pulse
    logic [15:0]      nv_wdata_r, nv_wdata_nxt; // store write data
    logic             power_r, power_nxt;       // host supply
    logic             lamp_r, lamp_nxt;         // lamp drive

    logic wr_flag, wr_commit, low_batt;         // decoded events
    assign wr_flag   = REG_WR && hit(REG_ADDR, ADDR_HOST_UP);
    assign wr_commit = REG_WR && hit(REG_ADDR, ADDR_COMMIT);
    assign low_batt  = VBAT < thr_r;

    // ==========================================================
    // next-state logic
    always_comb begin
        state_nxt    = state_r;
        flag_nxt     = flag_r;
        thr_nxt      = thr_r;
        loaded_nxt   = 1'b1;
        lamp_cnt_nxt = lamp_cnt_r;
        shdn_cnt_nxt = shdn_cnt_r;
        rdata_nxt    = rdata_r;
        nv_wr_nxt    = 1'b0;
        nv_wdata_nxt = nv_wdata_r;
        power_nxt    = power_r;
        lamp_nxt     = lamp_r;

        // restore committed threshold once after reset
        if (!loaded_r) begin
            thr_nxt = NV_VALID ? NV_RDATA : THR_RESET;
        end

        // threshold bytes are plain storage
        if (REG_WR && hit(REG_ADDR, ADDR_THR_LO)) begin
            thr_nxt[7:0] = REG_WDATA;
        end
        if (REG_WR && hit(REG_ADDR, ADDR_THR_HI)) begin
            thr_nxt[15:8] = REG_WDATA;
        end

        // commit copies the live threshold only on the key
        if (wr_commit && REG_WDATA == COMMIT_KEY) begin
            nv_wr_nxt    = 1'b1;
            nv_wdata_nxt = thr_r;
        end

        // register reads
        if (REG_RD) begin
            unique case (1'b1)
                hit(REG_ADDR, ADDR_THR_LO):  rdata_nxt = thr_r[7:0];
                hit(REG_ADDR, ADDR_THR_HI):  rdata_nxt = thr_r[15:8];
                hit(REG_ADDR, ADDR_COMMIT):  rdata_nxt = COMMIT_READ_VAL;
                hit(REG_ADDR, ADDR_HOST_UP): rdata_nxt = flag_r;
                default:                     rdata_nxt = BYTE_ZERO;
            endcase
        end

        // lamp pulse timer runs always, used in boot and shutdown
        if (lamp_cnt_r == LAMP_LAST) begin
            lamp_cnt_nxt = CNT_ZERO;
        end else begin
            lamp_cnt_nxt = lamp_cnt_r + CNT_ONE;
        end

        // host power state machine
        unique case (state_r)
            ST_OFF: begin
                lamp_nxt = 1'b0;
                flag_nxt = BYTE_ZERO;
                if (TOUCH) begin
                    state_nxt = ST_BOOT;
                    power_nxt = 1'b1;
                    flag_nxt  = BYTE_ZERO;
                end
            end
            ST_BOOT: begin
                // lamp pulses while booting
                if (lamp_cnt_r == LAMP_LAST) begin
                    lamp_nxt = !lamp_r;
                end
                if (wr_flag && REG_WDATA != BYTE_ZERO) begin
                    state_nxt = ST_RUN;
                    flag_nxt  = FLAG_SET;
                end else begin
                    flag_nxt = BYTE_ZERO;
                end
            end
            ST_RUN: begin
                lamp_nxt = 1'b1;
                if (TOUCH || low_batt || (wr_flag && REG_WDATA == BYTE_ZERO)) begin
                    state_nxt    = ST_SHDN;
                    flag_nxt     = BYTE_ZERO;
                    shdn_cnt_nxt = CNT_ZERO;
                end
            end
            ST_SHDN: begin
                // the daemon sees the cleared flag and halts the host
                flag_nxt = BYTE_ZERO;
                if (lamp_cnt_r == LAMP_LAST) begin
                    lamp_nxt = !lamp_r;
                end
                if (shdn_cnt_r == SHDN_LAST) begin
                    state_nxt = ST_OFF;
                    power_nxt = 1'b0;
                    flag_nxt  = BYTE_ZERO;
                end else begin
                    shdn_cnt_nxt = shdn_cnt_r + CNT_ONE;
                end
            end
        endcase
    end

    // ==========================================================
    // registers
    always_ff @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
            state_r    <= ST_OFF;
            flag_r     <= BYTE_ZERO;
            thr_r      <= THR_RESET;
            loaded_r   <= 1'b0;
            lamp_cnt_r <= CNT_ZERO;
            shdn_cnt_r <= CNT_ZERO;
            rdata_r    <= BYTE_ZERO;
            nv_wr_r    <= 1'b0;
            nv_wdata_r <= THR_RESET;
            power_r    <= 1'b0;
            lamp_r     <= 1'b0;
        end else if (CE) begin
            state_r    <= state_nxt;
            flag_r     <= flag_nxt;
            thr_r      <= thr_nxt;
            loaded_r   <= loaded_nxt;
            lamp_cnt_r <= lamp_cnt_nxt;
            shdn_cnt_r <= shdn_cnt_nxt;
            rdata_r    <= rdata_nxt;
            nv_wr_r    <= nv_wr_nxt;
            nv_wdata_r <= nv_wdata_nxt;
            power_r    <= power_nxt;
            lamp_r     <= lamp_nxt;
        end
    end

    // outputs straight from flops
    assign REG_RDATA  = rdata_r;
    assign NV_WR      = nv_wr_r;
    assign NV_WDATA   = nv_wdata_r;
    assign HOST_POWER = power_r;
    assign LAMP       = lamp_r;

    // ==========================================================
    // assertions
    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RSTN);

    AST_FLAG_ONLY_RUN: assert property ((flag_r != BYTE_ZERO) == (state_r == ST_RUN))
        else $error("host flag disagrees with run state");
    AST_BOOT_TO_RUN: assert property (CE && state_r == ST_BOOT && wr_flag && REG_WDATA != BYTE_ZERO
        |=> state_r == ST_RUN && flag_r == FLAG_SET)
        else $error("daemon flag write did not enter run");
    AST_LAMP_STEADY: assert property (CE && state_r == ST_RUN |=> lamp_r)
        else $error("lamp not steady while host runs");
    AST_TOUCH_CLEAR: assert property (CE && state_r == ST_RUN && TOUCH
        |=> state_r == ST_SHDN && flag_r == BYTE_ZERO)
        else $error("touch did not clear flag");
    AST_LOWBATT_CLEAR: assert property (CE && state_r == ST_RUN && VBAT < thr_r |=> state_r == ST_SHDN)
        else $error("low battery did not start shutdown");
    AST_WRITE_ZERO: assert property (CE && state_r == ST_RUN && wr_flag && REG_WDATA == BYTE_ZERO
        |=> state_r == ST_SHDN)
        else $error("flag write of zero did not start shutdown");
    AST_POWER_DROP: assert property (CE && state_r == ST_SHDN && shdn_cnt_r == SHDN_LAST
        |=> !power_r && state_r == ST_OFF && flag_r == BYTE_ZERO)
        else $error("power not removed at end of shutdown");
    AST_COMMIT_KEY: assert property (CE && wr_commit && REG_WDATA == COMMIT_KEY
        |=> nv_wr_r && nv_wdata_r == $past(thr_r))
        else $error("key write did not commit threshold");
    AST_COMMIT_OTHER: assert property (CE && wr_commit && REG_WDATA != COMMIT_KEY |=> !nv_wr_r)
        else $error("non-key commit write reached store");
    AST_COMMIT_READ: assert property (CE && REG_RD && hit(REG_ADDR, ADDR_COMMIT) |=> rdata_r == BYTE_ZERO)
        else $error("commit register read non-zero");

    COV_BOOT_RUN:   cover property (state_r == ST_BOOT ##1 state_r == ST_RUN);
    COV_SHDN_OFF:   cover property (state_r == ST_SHDN ##1 state_r == ST_OFF);
    COV_COMMIT:     cover property (nv_wr_r);
    COV_LOW_BATT:   cover property (state_r == ST_RUN && low_batt);

endmodule // host_power_ctrl

//--- testbench/host_daemon_model.sv
// host daemon model: master of the decoded register port
// assumes bench inputs change on the falling edge of the core clock
`timescale 1ns/1ps
module host_daemon_model #(
    parameter int BOOT_WAIT = 20 // cycles from power-on to daemon start
) (
    input  wire logic       clk,
    input  wire logic       host_power,
    input  wire logic [7:0] rdata,
    output logic            wr,
    output logic            rd,
    output logic      [7:0] addr,
    output logic      [7:0] wdata
);
    import host_power_pkg::*;
    logic [7:0] dq;        // read data of the daemon's own accesses
    logic       own_clear; // the daemon itself last wrote the flag to zero
    logic       reported;  // start flag written since the last power-on
    logic       halting;   // daemon has begun a host shutdown
    // ==========================================================
    // one access: hold over the taking edge, then release
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        wr = w;
        rd = !w;
        addr = a;
        wdata = d;
        @(negedge clk);
        q = rdata;
        wr = 1'b0;
        rd = 1'b0;
        addr = ~a; // released lines do not keep the last value
        wdata = ~d;
        // remember who cleared the flag, so a foreign clear can be told apart
        if (w && a == ADDR_HOST_UP) own_clear = (d == BYTE_ZERO);
    endtask
    // flag poll: a clear that the daemon did not make starts a host shutdown
    task automatic poll();
        acc(1'b0, ADDR_HOST_UP, BYTE_ZERO, dq);
        if (dq == BYTE_ZERO && !own_clear) halting = 1'b1;
    endtask
    // idle bus at time zero
    initial begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'hFF;
        wdata = 8'hFF;
        own_clear = 1'b0;
        reported = 1'b0;
        halting = 1'b0;
    end
    // daemon start: report the host up once booted
    always @(posedge host_power) begin
        reported = 1'b0;
        halting = 1'b0;
        repeat (BOOT_WAIT) @(negedge clk);
        acc(1'b1, ADDR_HOST_UP, FLAG_SET, dq);
        reported = 1'b1;
    end
endmodule // host_daemon_model

//--- testbench/host_power_state_and_config_commit_tb.sv
// bench for the host flag, power sequencing and config commit
// assumes short lamp and shutdown counts set through parameters
`timescale 1ns/1ps
module host_power_state_and_config_commit_tb;
    import host_power_pkg::*;
    logic        clk, rstn, ce, touch, nv_valid, nv_wr, host_power, lamp, wr, rd;
    logic [7:0]  addr, wdata, rdata, q;
    logic [15:0] vbat, nv_rdata, nv_wdata;
    int          n_fail = 0;
    int          tests_run = 0;
    int          n;
    // ==========================================================
    // design and daemon
    host_power_ctrl #(.LAMP_HALF_CYC(4), .SHDN_CYC(8)) dut_u (.CORE_CLK(clk), .RSTN(rstn), .CE(ce),
        .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .TOUCH(touch),
        .VBAT(vbat), .NV_RDATA(nv_rdata), .NV_VALID(nv_valid), .NV_WR(nv_wr), .NV_WDATA(nv_wdata),
        .HOST_POWER(host_power), .LAMP(lamp));
    host_daemon_model pm_u (.clk(clk), .host_power(host_power), .rdata(rdata), .wr(wr), .rd(rd),
        .addr(addr), .wdata(wdata));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr8(input logic [7:0] a, input logic [7:0] d);
        pm_u.acc(1'b1, a, d, q);
    endtask
    task automatic rd8(input logic [7:0] a);
        pm_u.acc(1'b0, a, 8'h00, q);
    endtask
    task automatic do_reset(input logic v, input logic [15:0] d);
        rstn = 1'b0;
        nv_valid = v;
        nv_rdata = d;
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        @(negedge clk);
    endtask
    // counts lamp changes over k cycles
    task automatic toggles(input int k);
        logic p;
        n = 0;
        p = lamp;
        repeat (k) begin
            @(negedge clk);
            if (lamp !== p) n++;
            p = lamp;
        end
    endtask
    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk("host_power", 16'h0000, {15'h0, host_power});
        chk("nv_wdata", THR_RESET, nv_wdata);
        rd8(ADDR_HOST_UP);
        chk("flag", 16'h0000, {8'h00, q});
        rd8(ADDR_COMMIT);
        chk("commit", 16'h0000, {8'h00, q});
        rd8(8'h55);
        chk("unmapped", 16'h0000, {8'h00, q});
    endtask
    task automatic t_commit();
        // a key write while the clock enable is low must not be taken
        ce = 1'b0;
        wr8(ADDR_COMMIT, COMMIT_KEY);
        chk("nv_wr frozen", 16'h0000, {15'h0, nv_wr});
        ce = 1'b1;
        wr8(ADDR_COMMIT, 8'h45);
        chk("nv_wr bad key", 16'h0000, {15'h0, nv_wr});
        wr8(ADDR_THR_LO, 8'h34);
        wr8(ADDR_THR_HI, 8'h12);
        wr8(ADDR_COMMIT, COMMIT_KEY);
        chk("nv_wr", 16'h0001, {15'h0, nv_wr});
        chk("nv_wdata", 16'h1234, nv_wdata);
        @(negedge clk);
        chk("nv_wr end", 16'h0000, {15'h0, nv_wr});
        rd8(ADDR_COMMIT);
        chk("commit read", 16'h0000, {8'h00, q});
        rd8(ADDR_THR_HI);
        chk("thr hi", 16'h0012, {8'h00, q});
    endtask
    task automatic t_restore();
        do_reset(1'b1, 16'h0ABC);
        rd8(ADDR_THR_LO);
        chk("stored lo", 16'h00BC, {8'h00, q});
        do_reset(1'b0, 16'h0ABC);
        rd8(ADDR_THR_LO);
        chk("default lo", 16'h005C, {8'h00, q});
        rd8(ADDR_THR_HI);
        chk("default hi", 16'h0002, {8'h00, q});
    endtask
    // boot, run, then shutdown by touch (0), low battery (1) or write zero (2)
    task automatic t_power(input int how);
        int i;
        touch = 1'b1;
        @(negedge clk);
        touch = 1'b0;
        chk("boot power", 16'h0001, {15'h0, host_power});
        wr8(ADDR_HOST_UP, BYTE_ZERO);
        rd8(ADDR_HOST_UP);
        chk("boot flag", 16'h0000, {8'h00, q});
        toggles(5);
        chk("boot pulsing", 16'h0001, {15'h0, n > 0});
        // touch while booting is ignored; the run flag check below shows it
        touch = 1'b1;
        @(negedge clk);
        touch = 1'b0;
        for (i = 0; i < 40 && pm_u.reported !== 1'b1; i++) @(negedge clk);
        chk("daemon up", 16'h0001, {15'h0, pm_u.reported});
        repeat (3) @(negedge clk);
        rd8(ADDR_HOST_UP);
        chk("run flag", 16'h0001, {8'h00, q});
        toggles(9);
        chk("steady lamp", 16'h0001, {15'h0, n == 0 && lamp === 1'b1});
        if (how == 0) begin
            touch = 1'b1;
            @(negedge clk);
            touch = 1'b0;
        end else if (how == 1) begin
            vbat = 16'h025B;
            @(negedge clk);
        end else begin
            wr8(ADDR_HOST_UP, BYTE_ZERO);
        end
        pm_u.poll();
        chk("cleared flag", 16'h0000, {8'h00, pm_u.dq});
        chk("daemon halt", {15'h0, how != 2}, {15'h0, pm_u.halting});
        chk("grace power", 16'h0001, {15'h0, host_power});
        toggles(5);
        chk("shdn pulsing", 16'h0001, {15'h0, n > 0});
        repeat (6) @(negedge clk);
        vbat = 16'hFFFF;
        chk("power off", 16'h0000, {15'h0, host_power});
        rd8(ADDR_HOST_UP);
        chk("off flag", 16'h0000, {8'h00, q});
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        touch = 1'b0;
        ce = 1'b1;
        vbat = 16'hFFFF;
        do_reset(1'b0, 16'h0000);
        t_reset();
        t_commit();
        t_restore();
        for (int k = 0; k < 3; k++) t_power(k);
        tally_and_finish();
    end
    initial begin
        #(25 * 5000);
        n_fail++;
        tally_and_finish();
    end
endmodule // host_power_state_and_config_commit_tb
